//--- fptc_fifo.sv
// fifo core: write/read port timing, configuration latch, offset registers
`timescale 1ns/1ps
// How it works
// - sync write stores word on gated clock
// - async write stores on strobe rising edge
// - write gate qualifies sync-mode data and offset writes
// - serial enable gates offset shifting
// - read timing select sampled at reset
// - write timing select sampled at reset
// - async ports only in ball-grid variant
// - sync read delivers word on gated clock
// - async read delivers on strobe edge
// - reset clears pointers, output, latches selects
// - offset access routes gated edges to offsets
module fptc_fifo
    import fptc_pkg::*;
#(
    parameter int DATA_W = fptc_pkg::FPTC_DATA_W,
    parameter int ADDR_W = fptc_pkg::FPTC_ADDR_W,
    parameter int OFS_W = fptc_pkg::FPTC_OFS_W,
    parameter bit BGA_PACKAGE = 1'b1
) (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, active high
    input wire logic full_reset, // full reset, active high, synchronous
    input wire logic write_port_timing_select, // 1 sync, 0 strobe write
    input wire logic read_port_timing_select, // 1 sync, 0 strobe read
    input wire logic fall_through_mode, // 1 fall-through timing requested
    input wire logic write_strobe, // write clock enable or strobe level
    input wire logic write_gate, // write enable, active high
    input wire logic read_strobe, // read clock enable or strobe level
    input wire logic read_gate, // read enable, active high
    input wire logic offset_access_select, // 1 offset registers instead of memory
    input wire logic serial_offset_load_enable, // serial offset shifting enable
    input wire logic serial_in, // serial offset data bit
    input wire logic [DATA_W-1:0] din, // write data
    output logic [DATA_W-1:0] dout, // read data, registered
    output logic empty, // memory empty
    output logic full, // memory full
    output logic almost_empty_flag, // low when fewer words than empty offset
    output logic almost_full_flag, // low when free slots at or below full offset
    output logic write_sync_mode, // latched write timing
    output logic read_sync_mode, // latched read timing
    output logic config_error // async read with fall-through requested
);
    import fptc_pkg::*;
    // ==========================================
    // parameter checks
    initial begin
        // serial chain holds both offsets, 2*OFS_W bits; offsets must fit below the data word
        if (DATA_W <= 2*OFS_W || ADDR_W < 2 || OFS_W < 2 || OFS_W > ADDR_W) begin
            $error("fptc_fifo: unsupported width or depth");
        end
    end
    localparam int DEPTH = 1 << ADDR_W;
    localparam logic [ADDR_W:0] DEPTH_C = (ADDR_W+1)'(DEPTH);
    // ==========================================
    // configuration latch
    fptc_state_t state_r;
    logic wsync_r, rsync_r, fall_through_mode_r;
    logic wstb_d_r, rstb_d_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= FPTC_ST_RESET;
        end else begin
            case (state_r)
                FPTC_ST_RESET: state_r <= FPTC_ST_CAPTURE;
                FPTC_ST_CAPTURE: if (!full_reset) state_r <= FPTC_ST_RUN;
                FPTC_ST_RUN: if (full_reset) state_r <= FPTC_ST_CAPTURE;
                default: state_r <= FPTC_ST_RESET;
            endcase
        end
    end
    wire logic in_reset = (state_r != FPTC_ST_RUN) || full_reset;
    // selects are caught while full reset is held; later changes are not seen
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wsync_r <= FPTC_SYNC;
            rsync_r <= FPTC_SYNC;
            fall_through_mode_r <= 1'b0;
        end else if (full_reset) begin
            wsync_r <= write_port_timing_select | ~BGA_PACKAGE;
            rsync_r <= read_port_timing_select | ~BGA_PACKAGE;
            fall_through_mode_r <= fall_through_mode;
        end
    end
    assign write_sync_mode = wsync_r;
    assign read_sync_mode = rsync_r;
    // fall-through with strobe read is illegal; flagged, standard timing kept
    assign config_error = ~rsync_r & fall_through_mode_r;
    // ==========================================
    // port event decode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wstb_d_r <= 1'b0;
            rstb_d_r <= 1'b0;
        end else begin
            wstb_d_r <= write_strobe;
            rstb_d_r <= read_strobe;
        end
    end
    // strobe mode ignores the gate, which the writer holds active anyway
    wire logic wr_ev = wsync_r ? (write_strobe & write_gate) : (write_strobe & ~wstb_d_r);
    wire logic rd_ev = rsync_r ? (read_strobe & read_gate) : (read_strobe & ~rstb_d_r);
    wire logic wr_mem = wr_ev & ~offset_access_select & ~in_reset;
    wire logic rd_mem = rd_ev & ~offset_access_select & ~in_reset;
    wire logic wr_ofs = wr_ev & offset_access_select & ~in_reset;
    wire logic rd_ofs = rd_ev & offset_access_select & ~in_reset;
    // ==========================================
    // memory and pointers
    logic [DATA_W-1:0] mem [DEPTH];
    logic [ADDR_W:0] wptr_r, rptr_r;
    logic [ADDR_W:0] count;
    assign count = wptr_r - rptr_r;
    assign empty = (count == '0);
    assign full = (count == DEPTH_C);
    wire logic do_wr = wr_mem & ~full;
    wire logic do_rd = rd_mem & ~empty;
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wptr_r[ADDR_W-1:0]] <= din;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wptr_r <= '0;
        end else if (full_reset) begin
            wptr_r <= '0;
        end else if (do_wr) begin
            wptr_r <= wptr_r + 1'b1;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rptr_r <= '0;
        end else if (full_reset) begin
            rptr_r <= '0;
        end else if (do_rd) begin
            rptr_r <= rptr_r + 1'b1;
        end
    end
    // ==========================================
    // offset registers: ae in low half, af in high half of the serial chain
    logic [OFS_W-1:0] ae_ofs_r, af_ofs_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ae_ofs_r <= FPTC_AE_OFS_RST;
            af_ofs_r <= FPTC_AF_OFS_RST;
        end else if (full_reset) begin
            ae_ofs_r <= FPTC_AE_OFS_RST;
            af_ofs_r <= FPTC_AF_OFS_RST;
        end else if (!in_reset && serial_offset_load_enable && write_gate && write_strobe) begin
            {af_ofs_r, ae_ofs_r} <= {af_ofs_r[OFS_W-2:0], ae_ofs_r, serial_in};
        end else if (wr_ofs && !serial_offset_load_enable) begin
            {af_ofs_r, ae_ofs_r} <= din[2*OFS_W-1:0];
        end
    end
    logic [ADDR_W:0] free_cnt;
    assign free_cnt = DEPTH_C - count;
    assign almost_empty_flag = (count >= {{(ADDR_W+1-OFS_W){1'b0}}, ae_ofs_r});
    assign almost_full_flag = (free_cnt > {{(ADDR_W+1-OFS_W){1'b0}}, af_ofs_r});
    // ==========================================
    // output register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dout <= FPTC_DOUT_RST;
        end else if (full_reset) begin
            dout <= FPTC_DOUT_RST;
        end else if (do_rd) begin
            dout <= mem[rptr_r[ADDR_W-1:0]];
        end else if (rd_ofs) begin
            dout <= {{(DATA_W-2*OFS_W){1'b0}}, af_ofs_r, ae_ofs_r};
        end
    end
    // ==========================================
    // checks
    a_full_write_ignored: assert property (@(posedge clk) disable iff (rst)
        (wr_mem && full) |=> $stable(wptr_r)) else $error("write when full moved pointer");
    a_sync_write_moves: assert property (@(posedge clk) disable iff (rst)
        (wsync_r && write_strobe && write_gate && !offset_access_select && !in_reset && !full)
        |=> wptr_r == $past(wptr_r) + 1'b1) else $error("gated sync write not stored");
    a_async_write_edge: assert property (@(posedge clk) disable iff (rst)
        (!wsync_r && !in_reset && !full_reset && !offset_access_select && !full && $rose(write_strobe))
        |=> wptr_r != $past(wptr_r)) else $error("strobe edge not stored");
    a_no_gate_no_write: assert property (@(posedge clk) disable iff (rst)
        (wsync_r && !write_gate && !full_reset) |=> $stable(wptr_r)) else $error("ungated write");
    a_serial_shift: assert property (@(posedge clk) disable iff (rst)
        (!in_reset && serial_offset_load_enable && write_gate && write_strobe)
        |=> ae_ofs_r[0] == $past(serial_in)) else $error("serial offset bit not shifted in");
    a_serial_gated: assert property (@(posedge clk) disable iff (rst)
        (!serial_offset_load_enable && !wr_ofs && !full_reset) |=> $stable(ae_ofs_r))
        else $error("offset changed without enable");
    a_read_latch: assert property (@(posedge clk) disable iff (rst)
        full_reset |=> rsync_r == ($past(read_port_timing_select) | ~BGA_PACKAGE))
        else $error("read select not latched");
    a_write_latch: assert property (@(posedge clk) disable iff (rst)
        full_reset |=> wsync_r == ($past(write_port_timing_select) | ~BGA_PACKAGE))
        else $error("write select not latched");
    a_fall_through_mode_report: assert property (@(posedge clk) disable iff (rst)
        full_reset |=> config_error == (~($past(read_port_timing_select) | ~BGA_PACKAGE) & $past(fall_through_mode)))
        else $error("fall-through with strobe read not reported");
    a_qfp_sync: assert property (@(posedge clk) disable iff (rst)
        !BGA_PACKAGE |-> (wsync_r && rsync_r)) else $error("async port in flat pack");
    a_sync_read: assert property (@(posedge clk) disable iff (rst)
        (rsync_r && read_strobe && read_gate && !offset_access_select && !in_reset && !empty)
        |=> rptr_r == $past(rptr_r) + 1'b1) else $error("gated sync read missed");
    a_empty_read_ignored: assert property (@(posedge clk) disable iff (rst)
        (rd_mem && empty) |=> $stable(rptr_r)) else $error("read when empty moved pointer");
    a_async_read: assert property (@(posedge clk) disable iff (rst)
        (!rsync_r && !in_reset && !full_reset && !offset_access_select && !empty && $rose(read_strobe))
        |=> rptr_r != $past(rptr_r)) else $error("read strobe missed");
    a_reset_clears: assert property (@(posedge clk) disable iff (rst)
        full_reset |=> (wptr_r == '0 && rptr_r == '0 && dout == FPTC_DOUT_RST))
        else $error("full reset did not clear");
    // offsets may be rewritten at the same edge, so the value read is the one before it
    a_offset_route: assert property (@(posedge clk) disable iff (rst)
        (rd_ofs && !do_rd) |=> dout[2*OFS_W-1:0] == $past({af_ofs_r, ae_ofs_r}))
        else $error("offset read missed");
endmodule

//--- fptc_pkg.sv
// package: constants and types for the fifo port timing and configuration block
package fptc_pkg;
    // ==========================================
    // widths and depths
    localparam int FPTC_DATA_W = 36;
    localparam int FPTC_ADDR_W = 4;
    localparam int FPTC_OFS_W = 4;
    // ==========================================
    // reset values
    localparam logic [FPTC_DATA_W-1:0] FPTC_DOUT_RST = 36'h0_0000_0000;
    localparam logic [FPTC_OFS_W-1:0] FPTC_AE_OFS_RST = 4'h2;
    localparam logic [FPTC_OFS_W-1:0] FPTC_AF_OFS_RST = 4'h2;
    // ==========================================
    // port timing encodings
    localparam logic FPTC_SYNC = 1'b1;
    localparam logic FPTC_ASYNC = 1'b0;
    // ==========================================
    // configuration state
    typedef enum logic [2:0] {
        FPTC_ST_RESET = 3'b001,
        FPTC_ST_CAPTURE = 3'b010,
        FPTC_ST_RUN = 3'b100
    } fptc_state_t;
endpackage

//--- fptc_ctl_model.sv
// partner model: writing and reading controller on the fifo data ports
`timescale 1ns/1ps
module fptc_ctl_model (
    input wire logic clk, // system clock
    output logic write_strobe, // write clock enable or strobe
    output logic write_gate, // write enable
    output logic read_strobe, // read clock enable or strobe
    output logic read_gate, // read enable
    output logic [fptc_pkg::FPTC_DATA_W-1:0] din // write data
);
    import fptc_pkg::*;
    // ==========================================
    // idle levels
    logic w_hold = 1'b0;
    initial begin
        write_strobe = 1'b0;
        write_gate = 1'b0;
        read_strobe = 1'b0;
        read_gate = 1'b0;
        din = '0;
    end
    // strobe mode: write gate parked active, read gate parked low
    task automatic set_mode(input logic sync_w);
        @(negedge clk);
        w_hold = ~sync_w;
        write_gate = ~sync_w;
        read_gate = 1'b0;
    endtask
    // strobe drops for a full cycle so every call is a fresh rising edge
    task automatic wr(input logic [FPTC_DATA_W-1:0] d, input logic g);
        @(negedge clk);
        din = d;
        write_gate = g | w_hold;
        write_strobe = 1'b1;
        @(negedge clk);
        write_strobe = 1'b0;
        write_gate = w_hold;
        din = ~d;
    endtask
    task automatic rd(input logic g);
        @(negedge clk);
        read_gate = g;
        read_strobe = 1'b1;
        @(negedge clk);
        read_strobe = 1'b0;
        read_gate = 1'b0;
    endtask
endmodule

//--- testbench.sv
// testbench: port timing, data path and offset checks of the fifo core
`timescale 1ns/1ps
module testbench;
    import fptc_pkg::*;
    localparam int DEPTH = 1 << FPTC_ADDR_W;
    localparam logic [7:0] SER_PAT = 8'h21;
    logic clk, rst, full_reset, write_port_timing_select, read_port_timing_select, fall_through_mode;
    logic write_strobe, write_gate, read_strobe, read_gate, offset_access_select;
    logic serial_offset_load_enable, serial_in;
    logic [FPTC_DATA_W-1:0] din, dout;
    logic empty, full, almost_empty_flag, almost_full_flag, write_sync_mode, read_sync_mode, config_error;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    fptc_fifo DUT (.clk, .rst, .full_reset, .write_port_timing_select, .read_port_timing_select,
        .fall_through_mode, .write_strobe, .write_gate, .read_strobe, .read_gate, .offset_access_select,
        .serial_offset_load_enable, .serial_in, .din, .dout, .empty, .full, .almost_empty_flag,
        .almost_full_flag, .write_sync_mode, .read_sync_mode, .config_error);
    fptc_ctl_model ctl (.clk, .write_strobe, .write_gate, .read_strobe, .read_gate, .din);
    // ==========================================
    // clock, timeout, report
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [FPTC_DATA_W-1:0] got, input logic [FPTC_DATA_W-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // selects move only while full_reset is high; standard mode always
    task automatic cfg(input logic ws, input logic rs, input logic ft);
        @(negedge clk);
        write_port_timing_select = ws;
        read_port_timing_select = rs;
        fall_through_mode = ft;
        full_reset = 1'b1;
        repeat (2) @(negedge clk);
        full_reset = 1'b0;
        ctl.set_mode(ws);
    endtask
    // ==========================================
    // tests
    initial begin
        rst = 1'b1;
        full_reset = 1'b0;
        write_port_timing_select = 1'b1;
        read_port_timing_select = 1'b1;
        fall_through_mode = 1'b0;
        offset_access_select = 1'b0;
        serial_offset_load_enable = 1'b0;
        serial_in = 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        cfg(1'b1, 1'b1, 1'b0);
        chk("empty", empty, 1'b1);
        chk("dout", dout, FPTC_DOUT_RST);
        chk("wmode", write_sync_mode, FPTC_SYNC);
        chk("rmode", read_sync_mode, FPTC_SYNC);
        $display("test reset done");
        ctl.wr(36'h1_2345_6789, 1'b1);
        ctl.wr(36'hF_0000_000F, 1'b0);
        ctl.wr(36'hA_BCDE_F012, 1'b1);
        ctl.rd(1'b1);
        chk("dout", dout, 36'h1_2345_6789);
        ctl.rd(1'b1);
        chk("dout", dout, 36'hA_BCDE_F012);
        chk("empty", empty, 1'b1);
        $display("test sync transfer done");
        for (int i = 0; i <= DEPTH; i++) ctl.wr(36'(i), 1'b1);
        chk("full", full, 1'b1);
        chk("afull", almost_full_flag, 1'b0);
        for (int i = 0; i < DEPTH; i++) begin
            ctl.rd(1'b1);
            chk("dout", dout, 36'(i));
        end
        chk("empty", empty, 1'b1);
        ctl.rd(1'b1);
        chk("dout", dout, 36'hF);
        $display("test full refusal done");
        offset_access_select = 1'b1;
        ctl.wr(36'h23, 1'b1);
        offset_access_select = 1'b0;
        ctl.wr(36'h1, 1'b1);
        ctl.wr(36'h2, 1'b1);
        chk("aempty", almost_empty_flag, 1'b0);
        chk("afull", almost_full_flag, 1'b1);
        // eight shifts: full offset bits first, msb first, ends with empty offset 1
        offset_access_select = 1'b1;
        serial_offset_load_enable = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            serial_in = SER_PAT[i];
            ctl.wr('0, 1'b1);
        end
        serial_offset_load_enable = 1'b0;
        ctl.rd(1'b1);
        chk("ofsrd", dout, 36'h21);
        offset_access_select = 1'b0;
        chk("aempty", almost_empty_flag, 1'b1);
        ctl.rd(1'b1);
        ctl.rd(1'b1);
        chk("dout", dout, 36'h2);
        $display("test offsets done");
        cfg(1'b0, 1'b0, 1'b0);
        chk("wmode", write_sync_mode, FPTC_ASYNC);
        chk("rmode", read_sync_mode, FPTC_ASYNC);
        chk("cfgerr", config_error, 1'b0);
        ctl.wr(36'h5_5AA5_5AA5, 1'b0);
        ctl.rd(1'b0);
        chk("dout", dout, 36'h5_5AA5_5AA5);
        $display("test strobe ports done");
        cfg(1'b1, 1'b1, 1'b1);
        chk("dout", dout, FPTC_DOUT_RST);
        chk("rmode", read_sync_mode, FPTC_SYNC);
        chk("cfgerr", config_error, 1'b0);
        ctl.wr(36'h9_8765_4321, 1'b1);
        ctl.rd(1'b1);
        chk("dout", dout, 36'h9_8765_4321);
        $display("test fall-through select done");
        end_sim();
    end
endmodule
